// >>> common/tec_pkg.sv
package tec_pkg;
  // Register byte offsets.
  localparam logic [11:0] TEC_CTRL_OFS   = 12'h000;
  localparam logic [11:0] TEC_DEVCTL_OFS = 12'h004;
  localparam logic [11:0] TEC_IMAP_OFS   = 12'h008;
  localparam logic [11:0] TEC_EMAP_OFS   = 12'h00C;
  localparam logic [11:0] TEC_DBGSTS_OFS = 12'h010;
  localparam logic [11:0] TEC_LOG0_OFS   = 12'h020;
  localparam logic [11:0] TEC_LOG1_OFS   = 12'h024;
  localparam logic [11:0] TEC_LOG2_OFS   = 12'h028;
  localparam logic [11:0] TEC_LOG3_OFS   = 12'h02C;
  // Register field positions and reset values.
  localparam int          TEC_CTRL_ECRC_BIT = 0;
  localparam int          TEC_CTRL_UP_BIT   = 1;
  localparam int          TEC_MPS_LSB       = 5;
  localparam int          TEC_STS_OVF_BIT   = 0;
  localparam int          TEC_STS_LOG_BIT   = 1;
  localparam int          TEC_STS_MAL_BIT   = 2;
  localparam logic [7:0]  TEC_MAP_RESET     = 8'h01;
  localparam logic [2:0]  TEC_MPS_RESET     = 3'h0;
  // Header field positions.
  localparam int          TEC_F_FMT_LSB   = 29;
  localparam int          TEC_F_TYPE_LSB  = 24;
  localparam int          TEC_F_TC_LSB    = 20;
  localparam int          TEC_F_TD        = 15;
  localparam int          TEC_F_EP        = 14;
  localparam int          TEC_F_ATTR_LSB  = 12;
  localparam int          TEC_F_LEN_LSB   = 0;
  localparam int          TEC_F_LBE_LSB   = 4;
  localparam int          TEC_F_MCODE_LSB = 0;
  // Lengths in doublewords.
  localparam logic [12:0] TEC_MPS_BASE_DW = 13'h0020;
  localparam logic [10:0] TEC_LEN_ZERO_DW = 11'h400;
  localparam logic [10:0] TEC_HDR3_DW     = 11'h003;
  localparam logic [10:0] TEC_HDR4_DW     = 11'h004;
  localparam logic [10:0] TEC_ECRC_DW     = 11'h001;
  localparam logic [9:0]  TEC_ONE_DW      = 10'h001;
  // Type encodings.
  localparam logic [4:0]  TEC_T_MEM   = 5'h00;
  localparam logic [4:0]  TEC_T_MEMLK = 5'h01;
  localparam logic [4:0]  TEC_T_IO    = 5'h02;
  localparam logic [4:0]  TEC_T_CFG0  = 5'h04;
  localparam logic [4:0]  TEC_T_CFG1  = 5'h05;
  localparam logic [4:0]  TEC_T_CPL   = 5'h0A;
  localparam logic [4:0]  TEC_T_CPLLK = 5'h0B;
  localparam logic [4:0]  TEC_T_TCFG  = 5'h1B;
  localparam logic [1:0]  TEC_T_MSG_HI = 2'h2;
  localparam logic [2:0]  TEC_RT_RC   = 3'h0;
  localparam logic [2:0]  TEC_RT_BC   = 3'h3;
  localparam logic [2:0]  TEC_RT_GR   = 3'h5;
  localparam logic [2:0]  TEC_RT_MAX  = 3'h5;
  // Message codes.
  localparam logic [7:0]  TEC_MC_UNLOCK  = 8'h00;
  localparam logic [7:0]  TEC_MC_PM_NAK  = 8'h14;
  localparam logic [7:0]  TEC_MC_PME     = 8'h18;
  localparam logic [7:0]  TEC_MC_TURNOFF = 8'h19;
  localparam logic [7:0]  TEC_MC_TO_ACK  = 8'h1B;
  localparam logic [7:0]  TEC_MC_INTX_LO = 8'h20;
  localparam logic [7:0]  TEC_MC_INTX_HI = 8'h27;
  localparam logic [7:0]  TEC_MC_ERR_COR = 8'h30;
  localparam logic [7:0]  TEC_MC_ERR_NF  = 8'h31;
  localparam logic [7:0]  TEC_MC_ERR_FAT = 8'h33;
  localparam logic [7:0]  TEC_MC_SPL     = 8'h50;

  typedef enum logic [1:0] {
    TEC_LOG_EMPTY = 2'b01,
    TEC_LOG_FULL  = 2'b10
  } tec_log_state_type;

  typedef struct packed {
    logic             valid;
    logic [3:0][31:0] hdr;
    logic [10:0]      pay_dw;
    logic [10:0]      len_dw;
    logic [31:0]      ecrc_rx;
    logic [31:0]      ecrc_calc;
    logic             consumed;
    logic             unsupported;
    logic             unexp_cpl;
  } tec_rx_type;

  typedef struct packed {
    logic       valid;
    logic [2:0] tc;
  } tec_tx_type;

  typedef struct packed {
    logic              ecrc_en;
    logic              upstream;
    logic [2:0]        max_payload_field;
    logic [7:0]        imap;
    logic [7:0]        emap;
    logic              ovf;
    logic              mal;
    tec_log_state_type lst;
    logic [3:0][31:0]  log;
    logic              cor;
    logic              nfe;
    logic              fat;
    logic [31:0]       rdata;
  } tec_state_type;
endpackage : tec_pkg

// >>> logic/tec_checker.sv
`timescale 1ns/1ps
// Function
// - Poisoned pass-through packet gives correctable; consumed poisoned gives non-fatal.
// - With checking enabled, compare the trailing digest of every packet with digest bit.
// - Digest failure: terminating packet non-fatal, pass-through packet correctable.
// - Non-posted unsupported correctable, other unsupported non-fatal, unexpected completion correctable.
// - Poisoned, digest, unsupported, unexpected and malformed packets capture the header log.
// - Overflow sets the overflow status flag, signals fatal, logs no header.
// - No requester role, so no completer abort or completion time-out logic.
// - No flow control protocol error detection on received traffic.
// - Ingress malformed checks at entry; failure is fatal and logs the header.
// - Illegal format and type combination is malformed.
// - Payload above the programmed maximum payload size is malformed.
// - Packets with data need length field equal to received payload.
// - Packets with digest need received length of header, payload and digest.
// - I/O and configuration requests: one doubleword, class zero, attributes zero, last enables zero.
// - Interrupt, power, error, unlock and power-limit messages need traffic class zero.
// - Route-to-root packets are malformed on the upstream port.
// - Broadcast-from-root packets are malformed on a downstream port.
// - Gathered-to-root packets: downstream only and turn-off acknowledge only.
// - Legacy interrupt messages are malformed on the upstream port.
// - Trusted configuration requests are malformed off the upstream port.
// - Ingress traffic class must map to channel zero by the ingress map.
// - Egress traffic class must map to channel zero by the egress map.
module tec_checker
  import tec_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b0
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB register bus
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Packet streams from the port
  input  wire tec_rx_type  rx_pkt,
  input  wire logic        rx_overflow,
  input  wire tec_tx_type  tx_pkt,
  // Severity outputs
  output logic             err_cor,
  output logic             err_nonfatal,
  output logic             err_fatal
);

  function automatic logic reg_mapped(input logic [11:0] a);
    case (a)
      TEC_CTRL_OFS, TEC_DEVCTL_OFS, TEC_IMAP_OFS, TEC_EMAP_OFS, TEC_DBGSTS_OFS,
      TEC_LOG0_OFS, TEC_LOG1_OFS, TEC_LOG2_OFS, TEC_LOG3_OFS: reg_mapped = 1'b1;
      default: reg_mapped = 1'b0;
    endcase
  endfunction : reg_mapped

  function automatic logic is_msg(input logic [4:0] t);
    is_msg = (t[4:3] == TEC_T_MSG_HI);
  endfunction : is_msg

  function automatic logic legal_fmt_type(input logic [1:0] f, input logic [4:0] t);
    case (t)
      TEC_T_MEM, TEC_T_MEMLK: legal_fmt_type = (t == TEC_T_MEM) || !f[1];
      TEC_T_IO, TEC_T_CFG0, TEC_T_CFG1, TEC_T_CPL, TEC_T_CPLLK, TEC_T_TCFG:
        legal_fmt_type = !f[0];
      default: legal_fmt_type = is_msg(t) && f[0] && (t[2:0] <= TEC_RT_MAX);
    endcase
  endfunction : legal_fmt_type

  function automatic logic is_intx(input logic [7:0] c);
    is_intx = (c >= TEC_MC_INTX_LO) && (c <= TEC_MC_INTX_HI);
  endfunction : is_intx

  function automatic logic tc0_msg(input logic [7:0] c);
    case (c)
      TEC_MC_UNLOCK, TEC_MC_PM_NAK, TEC_MC_PME, TEC_MC_TURNOFF, TEC_MC_TO_ACK,
      TEC_MC_ERR_COR, TEC_MC_ERR_NF, TEC_MC_ERR_FAT, TEC_MC_SPL: tc0_msg = 1'b1;
      default: tc0_msg = is_intx(c);
    endcase
  endfunction : tc0_msg

  tec_state_type st_r;
  tec_state_type st_nxt;

  // Decoded header fields.
  logic [1:0]  fmt;
  logic [4:0]  ptype;
  logic [2:0]  tc;
  logic        td;
  logic        ep;
  logic [1:0]  attr;
  logic [9:0]  len_f;
  logic [3:0]  last_be;
  logic [7:0]  mcode;
  logic [10:0] len_dw;
  logic [10:0] hdr_dw;
  logic [12:0] max_dw;
  logic        msg;
  logic        io_cfg;
  logic        np;
  logic        ecrc_fail;
  logic        mal;
  logic        ing_fat;
  logic        ing_nfe;
  logic        ing_cor;
  logic        log_ev;
  logic        egr_mal;
  logic        wr_acc;
  logic        rd_setup;
  logic [31:0] rd_word;

  assign fmt     = rx_pkt.hdr[0][TEC_F_FMT_LSB +: 2];
  assign ptype   = rx_pkt.hdr[0][TEC_F_TYPE_LSB +: 5];
  assign tc      = rx_pkt.hdr[0][TEC_F_TC_LSB +: 3];
  assign td      = rx_pkt.hdr[0][TEC_F_TD];
  assign ep      = rx_pkt.hdr[0][TEC_F_EP];
  assign attr    = rx_pkt.hdr[0][TEC_F_ATTR_LSB +: 2];
  assign len_f   = rx_pkt.hdr[0][TEC_F_LEN_LSB +: 10];
  assign last_be = rx_pkt.hdr[1][TEC_F_LBE_LSB +: 4];
  assign mcode   = rx_pkt.hdr[1][TEC_F_MCODE_LSB +: 8];
  assign len_dw  = (len_f == '0) ? TEC_LEN_ZERO_DW : {1'b0, len_f};
  assign hdr_dw  = fmt[0] ? TEC_HDR4_DW : TEC_HDR3_DW;
  assign max_dw  = TEC_MPS_BASE_DW << st_r.max_payload_field;
  assign msg     = is_msg(ptype);
  assign io_cfg  = (ptype == TEC_T_IO) || (ptype == TEC_T_CFG0) || (ptype == TEC_T_CFG1);
  // Reads and I/O or configuration writes expect a completion; memory writes do not.
  assign np      = !msg && (ptype != TEC_T_CPL) && (ptype != TEC_T_CPLLK) && (!fmt[1] || io_cfg);

  assign ecrc_fail = st_r.ecrc_en && td && (rx_pkt.ecrc_rx != rx_pkt.ecrc_calc);

  always_comb begin
    mal = 1'b0;
    if (!legal_fmt_type(fmt, ptype)) begin
      mal = 1'b1;
    end
    if (fmt[1] && ({2'b00, rx_pkt.pay_dw} > max_dw)) begin
      mal = 1'b1;
    end
    if (fmt[1] && (len_dw != rx_pkt.pay_dw)) begin
      mal = 1'b1;
    end
    if (td && (rx_pkt.len_dw != 11'(hdr_dw + rx_pkt.pay_dw + TEC_ECRC_DW))) begin
      mal = 1'b1;
    end
    if (io_cfg && ((len_f != TEC_ONE_DW) || (tc != '0) || (attr != '0) || (last_be != '0))) begin
      mal = 1'b1;
    end
    if (msg && tc0_msg(mcode) && (tc != '0)) begin
      mal = 1'b1;
    end
    if (msg && (ptype[2:0] == TEC_RT_RC) && st_r.upstream) begin
      mal = 1'b1;
    end
    if (msg && (ptype[2:0] == TEC_RT_BC) && !st_r.upstream) begin
      mal = 1'b1;
    end
    if (msg && (ptype[2:0] == TEC_RT_GR) && (st_r.upstream || (mcode != TEC_MC_TO_ACK))) begin
      mal = 1'b1;
    end
    if (msg && is_intx(mcode) && st_r.upstream) begin
      mal = 1'b1;
    end
    if ((ptype == TEC_T_TCFG) && !st_r.upstream) begin
      mal = 1'b1;
    end
    if (!st_r.imap[tc]) begin
      mal = 1'b1;
    end
  end

  assign ing_fat = rx_pkt.valid && mal;
  // Only the flags of a completer path exist; no requester-side checks are built.
  assign ing_nfe = rx_pkt.valid && !mal && (((ep || ecrc_fail) && rx_pkt.consumed) ||
                                            (rx_pkt.unsupported && !np));
  assign ing_cor = rx_pkt.valid && !mal && !ing_nfe &&
                   (((ep || ecrc_fail) && !rx_pkt.consumed) ||
                    (rx_pkt.unsupported && np) || rx_pkt.unexp_cpl);
  assign log_ev  = rx_pkt.valid && (mal || ep || ecrc_fail || rx_pkt.unsupported ||
                                    rx_pkt.unexp_cpl);
  assign egr_mal = tx_pkt.valid && !st_r.emap[tx_pkt.tc];

  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  always_comb begin
    rd_word = '0;
    case (paddr)
      TEC_CTRL_OFS: begin
        rd_word[TEC_CTRL_ECRC_BIT] = st_r.ecrc_en;
        rd_word[TEC_CTRL_UP_BIT]   = st_r.upstream;
      end
      TEC_DEVCTL_OFS: rd_word[TEC_MPS_LSB +: 3] = st_r.max_payload_field;
      TEC_IMAP_OFS:   rd_word[7:0] = st_r.imap;
      TEC_EMAP_OFS:   rd_word[7:0] = st_r.emap;
      TEC_DBGSTS_OFS: begin
        rd_word[TEC_STS_OVF_BIT] = st_r.ovf;
        rd_word[TEC_STS_LOG_BIT] = (st_r.lst == TEC_LOG_FULL);
        rd_word[TEC_STS_MAL_BIT] = st_r.mal;
      end
      TEC_LOG0_OFS: rd_word = st_r.log[0];
      TEC_LOG1_OFS: rd_word = st_r.log[1];
      TEC_LOG2_OFS: rd_word = st_r.log[2];
      TEC_LOG3_OFS: rd_word = st_r.log[3];
      default:      rd_word = '0;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    if (rd_setup) begin
      st_nxt.rdata = rd_word;
    end
    if (wr_acc) begin
      case (paddr)
        TEC_CTRL_OFS: begin
          st_nxt.ecrc_en  = pwdata[TEC_CTRL_ECRC_BIT];
          st_nxt.upstream = pwdata[TEC_CTRL_UP_BIT];
        end
        TEC_DEVCTL_OFS: st_nxt.max_payload_field  = pwdata[TEC_MPS_LSB +: 3];
        TEC_IMAP_OFS:   st_nxt.imap = pwdata[7:0];
        TEC_EMAP_OFS:   st_nxt.emap = pwdata[7:0];
        TEC_DBGSTS_OFS: begin
          if (pwdata[TEC_STS_OVF_BIT]) begin
            st_nxt.ovf = 1'b0;
          end
          if (pwdata[TEC_STS_MAL_BIT]) begin
            st_nxt.mal = 1'b0;
          end
          if (pwdata[TEC_STS_LOG_BIT]) begin
            st_nxt.lst = TEC_LOG_EMPTY;
          end
        end
        default: st_nxt.rdata = st_r.rdata;
      endcase
    end
    // Hardware sets come after the clears so a same-cycle event is never lost.
    // Overflow status flag.
    if (rx_overflow) begin
      st_nxt.ovf = 1'b1;
    end
    if (ing_fat || egr_mal) begin
      st_nxt.mal = 1'b1;
    end
    // The log holds the first header until software frees it, so later errors keep the cause.
    // Header capture.
    case (st_nxt.lst)
      TEC_LOG_EMPTY: begin
        if (log_ev) begin
          st_nxt.log = rx_pkt.hdr;
          st_nxt.lst = TEC_LOG_FULL;
        end
      end
      TEC_LOG_FULL: st_nxt.lst = TEC_LOG_FULL;
      default:      st_nxt.lst = TEC_LOG_EMPTY;
    endcase
    st_nxt.fat = ing_fat || egr_mal || rx_overflow;
    st_nxt.nfe = ing_nfe;
    st_nxt.cor = ing_cor;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r          <= '0;
      st_r.upstream <= IS_UPSTREAM;
      st_r.max_payload_field      <= TEC_MPS_RESET;
      st_r.imap     <= TEC_MAP_RESET;
      st_r.emap     <= TEC_MAP_RESET;
      st_r.lst      <= TEC_LOG_EMPTY;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata       = st_r.rdata;
  assign pready       = 1'b1;
  assign pslverr      = psel && penable && !reg_mapped(paddr);
  assign err_cor      = st_r.cor;
  assign err_nonfatal = st_r.nfe;
  assign err_fatal    = st_r.fat;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_OVF_FATAL: assert property (rx_overflow |=> err_fatal && st_r.ovf)
    else $error("Overflow did not raise fatal and flag.");
  AST_OVF_NOLOG: assert property (rx_overflow && !log_ev && !wr_acc &&
                                  st_r.lst == TEC_LOG_EMPTY |=> st_r.lst == TEC_LOG_EMPTY)
    else $error("Overflow filled the header log.");
  AST_MAL_FATAL: assert property (ing_fat |=> err_fatal && !err_nonfatal && !err_cor)
    else $error("Malformed packet not fatal alone.");
  AST_FMT_ILLEGAL: assert property (rx_pkt.valid &&
                                    !legal_fmt_type(fmt, ptype) |=> err_fatal)
    else $error("Illegal format and type not fatal.");
  AST_MPS: assert property (rx_pkt.valid && fmt[1] &&
                            ({2'b00, rx_pkt.pay_dw} > max_dw) |=> err_fatal)
    else $error("Oversize payload not fatal.");
  AST_LEN_FIELD: assert property (rx_pkt.valid && fmt[1] &&
                                  (len_dw != rx_pkt.pay_dw) |=> err_fatal)
    else $error("Length field mismatch not fatal.");
  AST_DIGEST_LEN: assert property (rx_pkt.valid && td &&
                                   (rx_pkt.len_dw != 11'(hdr_dw + rx_pkt.pay_dw + TEC_ECRC_DW))
                                   |=> err_fatal)
    else $error("Digest length mismatch not fatal.");
  AST_IO_CFG: assert property (rx_pkt.valid && io_cfg &&
                               (len_f != TEC_ONE_DW) |=> err_fatal)
    else $error("Wide I/O or configuration request not fatal.");
  AST_MSG_TC: assert property (rx_pkt.valid && msg &&
                               tc0_msg(mcode) && (tc != '0) |=> err_fatal)
    else $error("Control message off class zero not fatal.");
  AST_POIS_FWD: assert property (rx_pkt.valid && !mal && ep && !rx_pkt.consumed &&
                                 !rx_pkt.unsupported |=> err_cor && !err_nonfatal)
    else $error("Forwarded poisoned packet not advisory.");
  AST_POIS_TERM: assert property (rx_pkt.valid && !mal && ep && rx_pkt.consumed |=>
                                  err_nonfatal && !err_cor)
    else $error("Consumed poisoned packet not non-fatal.");
  AST_ECRC_TERM: assert property (rx_pkt.valid && !mal && ecrc_fail &&
                                  rx_pkt.consumed |=> err_nonfatal && !err_cor)
    else $error("Terminating digest failure not non-fatal.");
  AST_UR_NP: assert property (rx_pkt.valid && !mal && !ep && !ecrc_fail && np &&
                              rx_pkt.unsupported |=> err_cor && !err_nonfatal)
    else $error("Non-posted unsupported not advisory.");
  AST_UR_POSTED: assert property (rx_pkt.valid && !mal && rx_pkt.unsupported && !np |=>
                                  err_nonfatal && !err_cor)
    else $error("Posted unsupported not non-fatal.");
  AST_LOG: assert property (log_ev && st_r.lst == TEC_LOG_EMPTY |=>
                            st_r.lst == TEC_LOG_FULL && st_r.log == $past(rx_pkt.hdr))
    else $error("Header not captured.");
  AST_UP_RC: assert property (rx_pkt.valid && st_r.upstream && msg &&
                              ptype[2:0] == TEC_RT_RC |=> err_fatal)
    else $error("Route to root on upstream port accepted.");
  AST_BC_DOWN: assert property (rx_pkt.valid && !st_r.upstream && msg &&
                                ptype[2:0] == TEC_RT_BC |=> err_fatal)
    else $error("Broadcast on downstream port accepted.");
  AST_GATHER: assert property (rx_pkt.valid && msg && ptype[2:0] == TEC_RT_GR &&
                               mcode != TEC_MC_TO_ACK |=> err_fatal)
    else $error("Gathered packet other than turn-off acknowledge accepted.");
  AST_INTX_UP: assert property (rx_pkt.valid && st_r.upstream && msg &&
                                is_intx(mcode) |=> err_fatal)
    else $error("Legacy interrupt on upstream port accepted.");
  AST_TCFG_DOWN: assert property (rx_pkt.valid && !st_r.upstream &&
                                  ptype == TEC_T_TCFG |=> err_fatal)
    else $error("Trusted configuration off upstream port accepted.");
  AST_IMAP: assert property (rx_pkt.valid && !st_r.imap[tc] |=> err_fatal)
    else $error("Unmapped ingress class not fatal.");
  AST_EGR: assert property (egr_mal |=> err_fatal && st_r.mal)
    else $error("Unmapped egress class not fatal.");

  COV_OVF: cover property (rx_overflow ##1 err_fatal);
  COV_MAL: cover property (ing_fat ##1 err_fatal);
  COV_LOG_RELOCK: cover property (st_r.lst == TEC_LOG_FULL ##1 st_r.lst == TEC_LOG_EMPTY
                                  ##[1:20] st_r.lst == TEC_LOG_FULL);
  COV_NFE: cover property (ing_nfe ##1 err_nonfatal);
  COV_COR: cover property (ing_cor ##1 err_cor);

endmodule : tec_checker

// >>> verification/tec_link_model.sv
`timescale 1ns/1ps
module tec_link_model
  import tec_pkg::*;
(
  // Clock
  input  wire logic pclk,
  // Packet streams into the port
  output tec_rx_type rx_pkt,
  output logic       rx_overflow,
  output tec_tx_type tx_pkt
);
  initial begin
    rx_pkt = '0;
    rx_overflow = 1'b0;
    tx_pkt = '0;
  end
  // Idle cycles carry inverted stale fields, so a design that ignores valid is caught.
  task send(input tec_rx_type p);
    @(posedge pclk);
    rx_pkt <= p;
    @(posedge pclk);
    rx_pkt <= ~p;
  endtask : send
  task ovf;
    @(posedge pclk);
    rx_overflow <= 1'b1;
    @(posedge pclk);
    rx_overflow <= 1'b0;
  endtask : ovf
  task egress(input logic [2:0] tc);
    @(posedge pclk);
    tx_pkt <= '{1'b1, tc};
    @(posedge pclk);
    tx_pkt <= '{1'b0, ~tc};
  endtask : egress
endmodule : tec_link_model

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb
  import tec_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  tec_rx_type  rx_pkt;
  logic        rx_overflow;
  tec_tx_type  tx_pkt;
  logic        err_cor;
  logic        err_nonfatal;
  logic        err_fatal;
  logic [31:0] rdat;
  logic        rerr;
  int          err_count;
  int          total_checks;
  tec_rx_type  p;
  tec_rx_type  m [14];
  logic [0:13] up;
  logic [0:13] bad;

  tec_checker #(.IS_UPSTREAM(1'b0)) tec_checker_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pkt(rx_pkt),
    .rx_overflow(rx_overflow), .tx_pkt(tx_pkt), .err_cor(err_cor),
    .err_nonfatal(err_nonfatal), .err_fatal(err_fatal));
  tec_link_model link_inst (.pclk(pclk), .rx_pkt(rx_pkt), .rx_overflow(rx_overflow),
    .tx_pkt(tx_pkt));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task close_out;
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  initial begin
    #400us;
    err_count++;
    close_out();
  end

  task chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk

  // The master waits on pready itself; only the watchdog ends a hang.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rdat, x);
  endtask : rdc

  task pk(input tec_rx_type q, input logic [2:0] e);
    link_inst.send(q);
    #1;
    chk({29'h0, err_cor, err_nonfatal, err_fatal}, {29'h0, e});
  endtask : pk

  task lg(input tec_rx_type q);
    rdc(TEC_LOG0_OFS, q.hdr[0]);
    rdc(TEC_LOG1_OFS, q.hdr[1]);
    apb(1'b1, TEC_DBGSTS_OFS, 32'h0000_0002);
  endtask : lg

  function automatic tec_rx_type mk(logic [1:0] f, logic [4:0] t, logic [2:0] tc, logic td,
                                    logic [9:0] ln, logic [10:0] pay, logic [10:0] tot,
                                    logic [7:0] code);
    tec_rx_type q;
    q = '0;
    q.valid = 1'b1;
    q.hdr[0] = {1'b0, f, t, 1'b0, tc, 4'h0, td, 1'b0, 2'h0, 2'h0, ln};
    q.hdr[1] = {24'h0, code};
    q.pay_dw = pay;
    q.len_dw = tot;
    return q;
  endfunction : mk

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    err_count = 0;
    total_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(TEC_CTRL_OFS, 32'h0);
    rdc(TEC_DEVCTL_OFS, 32'h0);
    rdc(TEC_IMAP_OFS, 32'h1);
    rdc(TEC_EMAP_OFS, 32'h1);
    rdc(TEC_DBGSTS_OFS, 32'h0);
    rdc(TEC_LOG0_OFS, 32'h0);
    rdc(12'h014, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b1, TEC_IMAP_OFS, 32'h0000_00FF);
    rdc(TEC_IMAP_OFS, 32'h0000_00FF);
    pk(mk(2'h2, TEC_T_MEM, 3'h0, 1'b0, 10'h1, 11'h1, 11'h4, 8'h0), 3'b000);
    p = mk(2'h2, TEC_T_MEM, 3'h0, 1'b0, 10'h1, 11'h1, 11'h4, 8'h0);
    p.hdr[0][TEC_F_EP] = 1'b1;
    pk(p, 3'b100);
    rdc(TEC_DBGSTS_OFS, 32'h2);
    p.consumed = 1'b1;
    p.hdr[0][TEC_F_LEN_LSB] = 1'b1;
    pk(p, 3'b010);
    p.consumed = 1'b0;
    lg(p);
    p = mk(2'h2, TEC_T_MEM, 3'h0, 1'b1, 10'h1, 11'h1, 11'h5, 8'h0);
    p.ecrc_rx = 32'h0000_0001;
    pk(p, 3'b000);
    apb(1'b1, TEC_CTRL_OFS, 32'h1);
    pk(p, 3'b100);
    lg(p);
    p.consumed = 1'b1;
    pk(p, 3'b010);
    lg(p);
    p.ecrc_rx = 32'h0;
    pk(p, 3'b000);
    p = mk(2'h0, TEC_T_MEM, 3'h0, 1'b0, 10'h1, 11'h0, 11'h3, 8'h0);
    p.unsupported = 1'b1;
    pk(p, 3'b100);
    lg(p);
    p = mk(2'h2, TEC_T_MEM, 3'h0, 1'b0, 10'h1, 11'h1, 11'h4, 8'h0);
    p.unsupported = 1'b1;
    pk(p, 3'b010);
    lg(p);
    p = mk(2'h0, TEC_T_CPL, 3'h0, 1'b0, 10'h1, 11'h0, 11'h3, 8'h0);
    p.unexp_cpl = 1'b1;
    pk(p, 3'b100);
    lg(p);
    link_inst.ovf();
    #1;
    chk({31'h0, err_fatal}, 32'h1);
    rdc(TEC_DBGSTS_OFS, 32'h1);
    apb(1'b1, TEC_DBGSTS_OFS, 32'h1);
    rdc(TEC_DBGSTS_OFS, 32'h0);
    m[0] = mk(2'h2, 5'h0C, 3'h0, 1'b0, 10'h1, 11'h1, 11'h4, 8'h0);
    m[1] = mk(2'h2, TEC_T_MEM, 3'h0, 1'b0, 10'h21, 11'h21, 11'h24, 8'h0);
    m[2] = mk(2'h2, TEC_T_MEM, 3'h0, 1'b0, 10'h2, 11'h1, 11'h4, 8'h0);
    m[3] = mk(2'h2, TEC_T_MEM, 3'h0, 1'b1, 10'h1, 11'h1, 11'h4, 8'h0);
    m[4] = mk(2'h0, TEC_T_IO, 3'h0, 1'b0, 10'h2, 11'h0, 11'h3, 8'h0);
    m[5] = mk(2'h0, TEC_T_CFG0, 3'h1, 1'b0, 10'h1, 11'h0, 11'h3, 8'h0);
    m[6] = mk(2'h1, 5'h10, 3'h1, 1'b0, 10'h0, 11'h0, 11'h4, TEC_MC_ERR_COR);
    m[7] = mk(2'h1, 5'h10, 3'h0, 1'b0, 10'h0, 11'h0, 11'h4, TEC_MC_PME);
    m[8] = mk(2'h1, 5'h13, 3'h0, 1'b0, 10'h0, 11'h0, 11'h4, TEC_MC_TURNOFF);
    m[9] = mk(2'h1, 5'h15, 3'h0, 1'b0, 10'h0, 11'h0, 11'h4, TEC_MC_PME);
    m[10] = mk(2'h1, 5'h14, 3'h0, 1'b0, 10'h0, 11'h0, 11'h4, TEC_MC_INTX_LO);
    m[11] = mk(2'h0, TEC_T_TCFG, 3'h0, 1'b0, 10'h1, 11'h0, 11'h3, 8'h0);
    m[12] = mk(2'h1, 5'h15, 3'h0, 1'b0, 10'h0, 11'h0, 11'h4, TEC_MC_TO_ACK);
    m[13] = mk(2'h1, 5'h10, 3'h0, 1'b0, 10'h0, 11'h0, 11'h4, TEC_MC_PME);
    // Index 0 is the leftmost bit, so each flag lines up with its packet above.
    up = 14'h0048;
    bad = 14'h3FFC;
    for (int i = 0; i < 14; i++) begin
      apb(1'b1, TEC_CTRL_OFS, {30'h0, up[i], 1'b0});
      pk(m[i], {2'b00, bad[i]});
      rdc(TEC_DBGSTS_OFS, bad[i] ? 32'h6 : 32'h0);
      if (bad[i]) begin
        lg(m[i]);
        apb(1'b1, TEC_DBGSTS_OFS, 32'h4);
      end
    end
    // A larger programmed limit must let the oversize packet through.
    apb(1'b1, TEC_DEVCTL_OFS, 32'h0000_0020);
    rdc(TEC_DEVCTL_OFS, 32'h0000_0020);
    pk(m[1], 3'b000);
    rdc(TEC_DBGSTS_OFS, 32'h0);
    apb(1'b1, TEC_IMAP_OFS, 32'h1);
    pk(mk(2'h2, TEC_T_MEM, 3'h1, 1'b0, 10'h1, 11'h1, 11'h4, 8'h0), 3'b001);
    lg(mk(2'h2, TEC_T_MEM, 3'h1, 1'b0, 10'h1, 11'h1, 11'h4, 8'h0));
    apb(1'b1, TEC_DBGSTS_OFS, 32'h4);
    link_inst.egress(3'h0);
    #1;
    chk({31'h0, err_fatal}, 32'h0);
    link_inst.egress(3'h2);
    #1;
    chk({31'h0, err_fatal}, 32'h1);
    rdc(TEC_DBGSTS_OFS, 32'h4);
    close_out();
  end
endmodule : tb
